// ### hw/drc_map.svh
// Purpose: Address map, field positions and codes for the DMA host.
// Assumes: Channel registers sit in one block, one stride per channel.
// Notes:   Definitions only.
`ifndef DRC_MAP_SVH
`define DRC_MAP_SVH
`define DRC_CH_BASE      32'h0400_0020
`define DRC_CH_SHIFT     4
`define DRC_OFS_SRC      32'h0000_0000
`define DRC_OFS_DST      32'h0000_0004
`define DRC_OFS_CNT      32'h0000_0008
`define DRC_OFS_CTL      32'h0000_000C
`define DRC_OP_ADDR      32'h0400_0060
`define DRC_GAP_LO       32'h0400_0062
`define DRC_GAP_HI       32'h0400_006F
`define DRC_PERI_LO      32'h0400_0000
`define DRC_PERI_HI      32'h0400_01FF
`define DRC_OWN_LO       32'h0400_0020
`define DRC_OWN_HI       32'h0400_006F
`define DRC_CTL_EN       0
`define DRC_CTL_BURST    5
`define DRC_CTL_RELOAD   16
`define DRC_OP_START_VAL 32'h0000_0001
`define DRC_OP_STOP_VAL  32'h0000_0000
`define DRC_ZERO         32'h0000_0000
`define DRC_GRP_MASK     32'h0000_0003
`define DRC_GRP_SIZE     32'h0000_0004
`define DRC_CMD_START    2'h1
`define DRC_CMD_STBY     2'h2
`define DRC_CMD_POLL     2'h3
`define DRC_CHAN_TWO     2'h2
`define DRC_LAST_CHAN    2'h3
`define DRC_CHAN_STEP    2'h1
`define DRC_FIFO_DEPTH   8
`define DRC_WORD_W       32
`endif

// ### hw/drc_pkg.sv
// Purpose: Types shared by the DMA host files.
// Assumes: Nothing beyond the address map header.
// Notes:   Holds types only; numbers live in the map header.
package drc_pkg;
   typedef enum logic [1:0] {
      DRC_SZ_BYTE,
      DRC_SZ_WORD,
      DRC_SZ_LONG
   } drc_size_t;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_CLR_EN,
      ST_ZERO_CNT,
      ST_WR_SRC,
      ST_WR_DST,
      ST_WR_CNT,
      ST_WR_OP,
      ST_WR_CTL,
      ST_STBY_OP,
      ST_STBY_RD,
      ST_POLL
   } drc_state_t;
endpackage : drc_pkg

// ### hw/drc_fifo.sv
// Purpose: Small synchronous FIFO for status words read from the device.
// Assumes: One clock; writer honours in_ready, reader honours out_valid.
// Notes:   Extra pointer bit tells full from empty without a counter.
module drc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0]      wptr_ff;
   logic [AW:0]      rptr_ff;
   logic [AW:0]      nxt_wptr;
   logic [AW:0]      nxt_rptr;
   logic             full;
   logic             empty;
   logic             do_wr;

   always_comb begin
      empty    = (wptr_ff == rptr_ff);
      full     = (wptr_ff[AW] != rptr_ff[AW]) &&
                 (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
      in_ready = !full;
      out_valid = !empty;
      out_data = mem_ff[rptr_ff[AW-1:0]];
      do_wr    = in_valid && !full;
      nxt_wptr = do_wr ? wptr_ff + 1'b1 : wptr_ff;
      nxt_rptr = (out_ready && !empty) ? rptr_ff + 1'b1 : rptr_ff;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wptr_ff <= '0;
         rptr_ff <= '0;
      end else begin
         wptr_ff <= nxt_wptr;
         rptr_ff <= nxt_rptr;
      end
   end

   // The array holds no reset so it maps onto plain storage.
   always_ff @(posedge clk_sys) begin
      if (do_wr) begin
         mem_ff[wptr_ff[AW-1:0]] <= in_data;
      end
   end
endmodule : drc_fifo

// ### hw/drc_host.sv
// Purpose: Host that programs a four-channel DMA engine over its registers.
// Assumes: Device answers each access with a one-cycle reg_ack.
// Notes:   Bad jobs are refused with cmd_error and never reach the device.
`include "drc_map.svh"

// What this block does
// - Reload jobs always use burst mode.
// - Reload jobs use count multiple of four.
// - Operation register word-sized, others longword.
// - Clear channel enable before changing request source.
// - Standby: clear master enable, await completion.
// - Write operation then control register last.
// - Write zero to count before reuse.
// - Hold external request high while configuring.
// - Never touch the unused register gap.
// - Channels target only permitted peripherals.
// - Channel two reload burst uses count four.
module drc_host (
   input  wire logic                clk_sys,
   input  wire logic                rst,
   input  wire logic                cmd_valid,
   input  wire logic [1:0]          cmd_op,
   input  wire logic [1:0]          cmd_chan,
   input  wire logic [31:0]         cmd_src,
   input  wire logic [31:0]         cmd_dst,
   input  wire logic [31:0]         cmd_count,
   input  wire logic [31:0]         cmd_ctrl,
   output logic                     cmd_ready,
   output logic                     cmd_error,
   output logic                     standby_ok,
   output logic [31:0]              reg_addr,
   output logic [31:0]              reg_wdata,
   output drc_pkg::drc_size_t       reg_size,
   output logic                     reg_wr,
   output logic                     reg_rd,
   input  wire logic [31:0]         reg_rdata,
   input  wire logic                reg_ack,
   output logic                     cfg_req_hold,
   output logic                     stat_valid,
   input  wire logic                stat_ready,
   output logic [31:0]              stat_data
);
   drc_pkg::drc_state_t state_ff,   nxt_state;
   drc_pkg::drc_size_t  size_ff,    nxt_size;
   logic [31:0]         addr_ff,    nxt_addr;
   logic [31:0]         wdata_ff,   nxt_wdata;
   logic                wr_ff,      nxt_wr;
   logic                rd_ff,      nxt_rd;
   logic                pend_ff,    nxt_pend;
   logic                ready_ff,   nxt_ready;
   logic                err_ff,     nxt_err;
   logic                stby_ff,    nxt_stby;
   logic                hold_ff,    nxt_hold;
   logic [1:0]          chan_ff,    nxt_chan;
   logic [31:0]         src_ff,     nxt_src;
   logic [31:0]         dst_ff,     nxt_dst;
   logic [31:0]         cnt_ff,     nxt_cnt;
   logic [31:0]         ctl_ff,     nxt_ctl;
   logic [31:0]         acc_addr;
   logic [31:0]         acc_data;
   logic                acc_wr;
   logic                acc_go;
   drc_pkg::drc_state_t acc_next;
   logic                push;
   logic                fifo_in_ready;
   logic                job_ok;
   logic                reload;

   function automatic logic [31:0] chan_addr(input logic [1:0] ch,
                                             input logic [31:0] ofs);
      chan_addr = `DRC_CH_BASE + ({30'h0000_0000, ch} << `DRC_CH_SHIFT) +
                  ofs;
   endfunction : chan_addr

   function automatic logic in_gap(input logic [31:0] a);
      in_gap = (a >= `DRC_GAP_LO) && (a <= `DRC_GAP_HI);
   endfunction : in_gap

   // External memory, or the peripheral window outside the engine itself.
   function automatic logic tgt_ok(input logic [31:0] a);
      tgt_ok = (a < `DRC_PERI_LO) ||
               ((a <= `DRC_PERI_HI) && !((a >= `DRC_OWN_LO) &&
                                          (a <= `DRC_OWN_HI)));
   endfunction : tgt_ok

   drc_fifo #(
      .WIDTH (`DRC_WORD_W),
      .DEPTH (`DRC_FIFO_DEPTH)
   ) u_stat_fifo (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (reg_rdata),
      .out_valid (stat_valid),
      .out_ready (stat_ready),
      .out_data  (stat_data)
   );

   always_comb begin
      reload = cmd_ctrl[`DRC_CTL_RELOAD];
      job_ok = tgt_ok(cmd_src) && tgt_ok(cmd_dst) &&
               (!reload || (((cmd_count & `DRC_GRP_MASK) == `DRC_ZERO) &&
                            (cmd_count != `DRC_ZERO))) &&
               (!(reload && (cmd_chan == `DRC_CHAN_TWO)) ||
                (cmd_count == `DRC_GRP_SIZE));
   end

   // Per-state access description; the handshake below is shared.
   always_comb begin
      acc_addr = `DRC_OP_ADDR;
      acc_data = `DRC_ZERO;
      acc_wr   = 1'b1;
      acc_go   = 1'b1;
      acc_next = drc_pkg::ST_IDLE;
      case (state_ff)
         drc_pkg::ST_CLR_EN: begin
            acc_addr = chan_addr(chan_ff, `DRC_OFS_CTL);
            acc_data = ctl_ff & ~(32'h0000_0001 << `DRC_CTL_EN);
            acc_next = drc_pkg::ST_ZERO_CNT;
         end
         drc_pkg::ST_ZERO_CNT: begin
            acc_addr = chan_addr(chan_ff, `DRC_OFS_CNT);
            acc_data = `DRC_ZERO;
            acc_next = drc_pkg::ST_WR_SRC;
         end
         drc_pkg::ST_WR_SRC: begin
            acc_addr = chan_addr(chan_ff, `DRC_OFS_SRC);
            acc_data = src_ff;
            acc_next = drc_pkg::ST_WR_DST;
         end
         drc_pkg::ST_WR_DST: begin
            acc_addr = chan_addr(chan_ff, `DRC_OFS_DST);
            acc_data = dst_ff;
            acc_next = drc_pkg::ST_WR_CNT;
         end
         drc_pkg::ST_WR_CNT: begin
            acc_addr = chan_addr(chan_ff, `DRC_OFS_CNT);
            acc_data = cnt_ff;
            acc_next = drc_pkg::ST_WR_OP;
         end
         drc_pkg::ST_WR_OP: begin
            acc_data = `DRC_OP_START_VAL;
            acc_next = drc_pkg::ST_WR_CTL;
         end
         drc_pkg::ST_WR_CTL: begin
            acc_addr = chan_addr(chan_ff, `DRC_OFS_CTL);
            acc_data = ctl_ff;
         end
         drc_pkg::ST_STBY_OP: begin
            acc_data = `DRC_OP_STOP_VAL;
            acc_next = drc_pkg::ST_STBY_RD;
         end
         drc_pkg::ST_STBY_RD: begin
            acc_addr = chan_addr(chan_ff, `DRC_OFS_CNT);
            acc_wr   = 1'b0;
         end
         drc_pkg::ST_POLL: begin
            acc_wr = 1'b0;
            // Holding off the read while full keeps every status word.
            acc_go = fifo_in_ready;
         end
         default: begin
            acc_go = 1'b0;
         end
      endcase
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_size  = size_ff;
      nxt_addr  = addr_ff;
      nxt_wdata = wdata_ff;
      nxt_wr    = wr_ff;
      nxt_rd    = rd_ff;
      nxt_pend  = pend_ff;
      nxt_ready = ready_ff;
      nxt_err   = 1'b0;
      nxt_stby  = stby_ff;
      nxt_hold  = hold_ff;
      nxt_chan  = chan_ff;
      nxt_src   = src_ff;
      nxt_dst   = dst_ff;
      nxt_cnt   = cnt_ff;
      nxt_ctl   = ctl_ff;
      push      = 1'b0;
      if (state_ff == drc_pkg::ST_IDLE) begin
         if (cmd_valid && ready_ff) begin
            nxt_chan = cmd_chan;
            nxt_src  = cmd_src;
            nxt_dst  = cmd_dst;
            nxt_cnt  = cmd_count;
            nxt_ctl  = cmd_ctrl;
            if (reload) begin
               nxt_ctl[`DRC_CTL_BURST] = 1'b1;
            end
            nxt_ready = 1'b0;
            case (cmd_op)
               `DRC_CMD_START: begin
                  if (job_ok) begin
                     nxt_state = drc_pkg::ST_CLR_EN;
                     nxt_stby  = 1'b0;
                     nxt_hold  = 1'b1;
                  end else begin
                     nxt_err   = 1'b1;
                     nxt_ready = 1'b1;
                  end
               end
               `DRC_CMD_STBY: begin
                  nxt_state = drc_pkg::ST_STBY_OP;
                  nxt_chan  = 2'h0;
               end
               `DRC_CMD_POLL: begin
                  nxt_state = drc_pkg::ST_POLL;
               end
               default: begin
                  nxt_err   = 1'b1;
                  nxt_ready = 1'b1;
               end
            endcase
         end
      end else if (!pend_ff) begin
         if (acc_go) begin
            nxt_pend  = 1'b1;
            nxt_addr  = acc_addr;
            nxt_wdata = acc_data;
            nxt_wr    = acc_wr;
            nxt_rd    = !acc_wr;
            nxt_size  = (acc_addr == `DRC_OP_ADDR) ?
                        drc_pkg::DRC_SZ_WORD : drc_pkg::DRC_SZ_LONG;
         end
      end else if (reg_ack) begin
         nxt_pend  = 1'b0;
         nxt_wr    = 1'b0;
         nxt_rd    = 1'b0;
         nxt_state = acc_next;
         case (state_ff)
            drc_pkg::ST_WR_CTL: begin
               nxt_ready = 1'b1;
               nxt_hold  = 1'b0;
            end
            drc_pkg::ST_POLL: begin
               push      = 1'b1;
               nxt_ready = 1'b1;
            end
            drc_pkg::ST_STBY_RD: begin
               // Re-read the same channel until its count drains.
               nxt_state = drc_pkg::ST_STBY_RD;
               if (reg_rdata == `DRC_ZERO) begin
                  if (chan_ff == `DRC_LAST_CHAN) begin
                     nxt_state = drc_pkg::ST_IDLE;
                     nxt_stby  = 1'b1;
                     nxt_ready = 1'b1;
                  end else begin
                     nxt_chan = chan_ff + `DRC_CHAN_STEP;
                  end
               end
            end
            default: begin
               nxt_ready = nxt_ready;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_ff <= drc_pkg::ST_IDLE;
         size_ff  <= drc_pkg::DRC_SZ_LONG;
         addr_ff  <= 32'h0000_0000;
         wdata_ff <= 32'h0000_0000;
         wr_ff    <= 1'b0;
         rd_ff    <= 1'b0;
         pend_ff  <= 1'b0;
         ready_ff <= 1'b1;
         err_ff   <= 1'b0;
         stby_ff  <= 1'b0;
         hold_ff  <= 1'b0;
         chan_ff  <= 2'h0;
         src_ff   <= 32'h0000_0000;
         dst_ff   <= 32'h0000_0000;
         cnt_ff   <= 32'h0000_0000;
         ctl_ff   <= 32'h0000_0000;
      end else begin
         state_ff <= nxt_state;
         size_ff  <= nxt_size;
         addr_ff  <= nxt_addr;
         wdata_ff <= nxt_wdata;
         wr_ff    <= nxt_wr;
         rd_ff    <= nxt_rd;
         pend_ff  <= nxt_pend;
         ready_ff <= nxt_ready;
         err_ff   <= nxt_err;
         stby_ff  <= nxt_stby;
         hold_ff  <= nxt_hold;
         chan_ff  <= nxt_chan;
         src_ff   <= nxt_src;
         dst_ff   <= nxt_dst;
         cnt_ff   <= nxt_cnt;
         ctl_ff   <= nxt_ctl;
      end
   end

   assign cmd_ready    = ready_ff;
   assign cmd_error    = err_ff;
   assign standby_ok   = stby_ff;
   assign reg_addr     = addr_ff;
   assign reg_wdata    = wdata_ff;
   assign reg_size     = size_ff;
   assign reg_wr       = wr_ff;
   assign reg_rd       = rd_ff;
   assign cfg_req_hold = hold_ff;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_gap_never_hit: assert property ((reg_wr || reg_rd) |-> !in_gap(reg_addr))
      else $error("Access landed in the unused gap.");
   a_op_word_size: assert property ((reg_wr || reg_rd) &&
      (reg_addr == `DRC_OP_ADDR) |-> reg_size == drc_pkg::DRC_SZ_WORD)
      else $error("Operation register not accessed as word.");
   a_reload_burst: assert property (reg_wr &&
      (state_ff == drc_pkg::ST_WR_CTL) && reg_wdata[`DRC_CTL_RELOAD]
      |-> reg_wdata[`DRC_CTL_BURST])
      else $error("Reload written without burst mode.");
   a_reload_count: assert property (reg_wr &&
      (state_ff == drc_pkg::ST_WR_CNT) && ctl_ff[`DRC_CTL_RELOAD]
      |-> (reg_wdata & `DRC_GRP_MASK) == `DRC_ZERO)
      else $error("Reload count not a multiple of four.");
   a_chan_two_cnt: assert property (reg_wr &&
      (state_ff == drc_pkg::ST_WR_CNT) && ctl_ff[`DRC_CTL_RELOAD] &&
      (chan_ff == `DRC_CHAN_TWO) |-> reg_wdata == `DRC_GRP_SIZE)
      else $error("Channel two reload count is not four.");
   a_enable_clear: assert property (reg_wr &&
      (state_ff == drc_pkg::ST_CLR_EN) |-> !reg_wdata[`DRC_CTL_EN])
      else $error("Request source rewritten with enable set.");
   a_count_zeroed: assert property ((state_ff == drc_pkg::ST_ZERO_CNT) &&
      reg_ack |=> state_ff == drc_pkg::ST_WR_SRC && !reg_wr)
      else $error("Count zero write not followed by source write.");
   a_ctl_last: assert property ((state_ff == drc_pkg::ST_WR_CTL) &&
      reg_ack |=> (state_ff == drc_pkg::ST_IDLE) ##1 !reg_wr)
      else $error("Control write was not the last step.");
   a_stby_drained: assert property ($rose(standby_ok) |->
      $past(reg_ack) && ($past(reg_rdata) == `DRC_ZERO))
      else $error("Standby reported before count drained.");
   a_hold_cfg: assert property (reg_wr &&
      (state_ff inside {drc_pkg::ST_WR_SRC, drc_pkg::ST_WR_CNT})
      |-> cfg_req_hold)
      else $error("Request line released during setup.");
   a_tgt_ok: assert property (reg_wr &&
      (state_ff inside {drc_pkg::ST_WR_SRC, drc_pkg::ST_WR_DST})
      |-> tgt_ok(reg_wdata))
      else $error("Channel aimed at a forbidden target.");

   c_job_done: cover property ((state_ff == drc_pkg::ST_WR_CTL) && reg_ack);
   c_stby_done: cover property ($rose(standby_ok));
   c_poll_push: cover property (push);
   c_job_refused: cover property (cmd_error);
endmodule : drc_host

// ### dv/drc_dev_model.sv
// Purpose: Behavioural model of the DMA engine behind the register link.
// Assumes: One access at a time; ack is a one-cycle pulse.
// Notes:   Counts host misuse in viol_cnt. Each active channel moves one word per cycle.
`include "drc_map.svh"
module drc_dev_model (
   input  wire logic               clk_sys,
   input  wire logic               rst,
   input  wire logic [31:0]        reg_addr,
   input  wire logic [31:0]        reg_wdata,
   input  wire drc_pkg::drc_size_t reg_size,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic      [31:0]        reg_rdata,
   output logic                    reg_ack,
   input  wire logic               slow,
   input  wire logic               nmi_in,
   output int                      viol_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] src_q [4];
   logic [31:0] sini_q [4];
   logic [31:0] dst_q [4];
   logic [31:0] cnt_q [4];
   logic [31:0] ctl_q [4];
   logic [1:0]  grp_q [4];
   logic [3:0]  act_q;
   logic [3:0]  zero_q;
   logic [31:0] op_q;
   logic        op_seen_q;
   logic        done_q;
   logic        bus_req_q;
   logic        irq_q;
   logic [1:0]  ch;
   logic        in_ch;
   int          wt;
   int          v;
   assign in_ch = reg_addr >= `DRC_CH_BASE && reg_addr < `DRC_OP_ADDR;
   assign ch = 2'((reg_addr - `DRC_CH_BASE) >> `DRC_CH_SHIFT);
   // Idle read data flips every cycle so a stale sample never looks valid.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_ack <= 1'b0;
         reg_rdata <= 32'h0000_0000;
         {op_q, op_seen_q, done_q, bus_req_q, irq_q} <= '0;
         {act_q, zero_q} <= '0;
         wt <= 0;
         viol_cnt <= 0;
         for (int i = 0; i < 4; i++) begin
            {src_q[i], sini_q[i], dst_q[i], cnt_q[i], ctl_q[i]} <= '0;
            grp_q[i] <= 2'h0;
         end
      end else begin
         v = 0;
         reg_ack <= 1'b0;
         reg_rdata <= ~reg_rdata;
         bus_req_q <= 1'b0;
         if (nmi_in) op_q[1] <= 1'b1;
         for (int i = 0; i < 4; i++) begin
            if (ctl_q[i][0] && op_q[0]) act_q[i] <= 1'b1;
            if (act_q[i] && ctl_q[i][0] && cnt_q[i] != 32'h0000_0000) begin
               cnt_q[i] <= cnt_q[i] - 32'h0000_0001;
               dst_q[i] <= dst_q[i] + 32'h0000_0004;
               grp_q[i] <= grp_q[i] + 2'h1;
               bus_req_q <= !(ctl_q[i][16] && grp_q[i] == 2'h3);
               if (ctl_q[i][16] && grp_q[i] == 2'h3) src_q[i] <= sini_q[i];
               else src_q[i] <= src_q[i] + 32'h0000_0004;
               if (cnt_q[i] == 32'h0000_0001) begin
                  act_q[i] <= 1'b0;
                  irq_q <= ctl_q[i][2];
               end
            end
         end
         if (!(reg_wr || reg_rd)) begin
            done_q <= 1'b0;
            wt <= 0;
         end else if (!done_q && wt < (slow ? 4 : 0)) begin
            wt <= wt + 1;
         end else if (!done_q) begin
            reg_ack <= 1'b1;
            done_q <= 1'b1;
            if (reg_addr >= `DRC_GAP_LO && reg_addr <= `DRC_GAP_HI) v++;
            if (!in_ch && reg_addr != `DRC_OP_ADDR) v++;
            if ((reg_addr == `DRC_OP_ADDR) != (reg_size == drc_pkg::DRC_SZ_WORD)) v++;
            if (reg_rd) begin
               if (reg_addr == `DRC_OP_ADDR) reg_rdata <= op_q;
               else case (reg_addr[3:0])
                  4'h0: reg_rdata <= src_q[ch];
                  4'h4: reg_rdata <= dst_q[ch];
                  4'h8: reg_rdata <= cnt_q[ch];
                  default: reg_rdata <= ctl_q[ch];
               endcase
            end else if (reg_addr == `DRC_OP_ADDR) begin
               op_q <= reg_wdata;
               op_seen_q <= 1'b1;
            end else if (in_ch) begin
               case (reg_addr[3:0])
                  4'h0: begin
                     src_q[ch] <= reg_wdata;
                     sini_q[ch] <= reg_wdata;
                  end
                  4'h4: dst_q[ch] <= reg_wdata;
                  4'h8: begin
                     if (reg_wdata != 32'h0000_0000 && !zero_q[ch]) v++;
                     zero_q[ch] <= reg_wdata == 32'h0000_0000;
                     cnt_q[ch] <= reg_wdata;
                  end
                  default: begin
                     if (reg_wdata[0] && ctl_q[ch][0]) v++;
                     if (reg_wdata[0] && !op_seen_q) v++;
                     if (reg_wdata[0] && reg_wdata[16] && !reg_wdata[5]) v++;
                     if (reg_wdata[0] && reg_wdata[16] && cnt_q[ch][1:0] != 2'h0) v++;
                     if (reg_wdata[16] && ch == 2'h2 && cnt_q[ch] != 32'h0000_0004 && reg_wdata[0]) v++;
                     if (!reg_wdata[0]) begin
                        op_seen_q <= 1'b0;
                        act_q[ch] <= 1'b0;
                     end
                     grp_q[ch] <= 2'h0;
                     ctl_q[ch] <= reg_wdata;
                  end
               endcase
            end
         end
         viol_cnt <= viol_cnt + v;
      end
   end
endmodule : drc_dev_model

// ### dv/dma_reload_indirect_channel_tb_top.sv
// Purpose: Self-checking bench for the DMA host against the device model.
// Assumes: Inputs change on the falling edge of clk_sys.
// Notes:   Rows hold ordinary jobs; standby, status and FIFO cases follow.
module dma_reload_indirect_channel_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [1:0]  op;
      logic [1:0]  chan;
      logic [31:0] src;
      logic [31:0] dst;
      logic [31:0] cnt;
      logic [31:0] ctl;
      logic        slow;
      logic        err;
   } drc_row_t;
   logic               clk_sys = 1'b0;
   logic               rst = 1'b1;
   logic               cmd_valid = 1'b0;
   logic [1:0]         cmd_op = 2'h0;
   logic [1:0]         cmd_chan = 2'h0;
   logic [31:0]        cmd_src = 32'h0000_0000;
   logic [31:0]        cmd_dst = 32'h0000_0000;
   logic [31:0]        cmd_count = 32'h0000_0000;
   logic [31:0]        cmd_ctrl = 32'h0000_0000;
   logic               stat_ready = 1'b0;
   logic               slow = 1'b0;
   logic               nmi_in = 1'b0;
   logic               in_start = 1'b0;
   logic               cmd_ready;
   logic               cmd_error;
   logic               standby_ok;
   logic [31:0]        reg_addr;
   logic [31:0]        reg_wdata;
   drc_pkg::drc_size_t reg_size;
   logic               reg_wr;
   logic               reg_rd;
   logic [31:0]        reg_rdata;
   logic               reg_ack;
   logic               cfg_req_hold;
   logic               stat_valid;
   logic [31:0]        stat_data;
   int                 viol_cnt;
   int                 err_total = 0;
   int                 checks = 0;
   int                 got;
   logic               ge;
   drc_row_t           rows [8];
   always #12.5 clk_sys = ~clk_sys;
   drc_host dut_u (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_chan(cmd_chan), .cmd_src(cmd_src),
      .cmd_dst(cmd_dst), .cmd_count(cmd_count), .cmd_ctrl(cmd_ctrl),
      .cmd_ready(cmd_ready), .cmd_error(cmd_error), .standby_ok(standby_ok),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_size(reg_size),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack), .cfg_req_hold(cfg_req_hold),
      .stat_valid(stat_valid), .stat_ready(stat_ready),
      .stat_data(stat_data));
   drc_dev_model dev_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_size(reg_size), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .slow(slow), .nmi_in(nmi_in), .viol_cnt(viol_cnt));
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   task automatic check(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic timed_out();
      check(1'b0, "wait ran out");
      give_verdict();
   endtask : timed_out
   task automatic offer(input drc_row_t r);
      int n;
      // One edge passes first, so a back-to-back offer never lowers and
      // raises cmd_valid in the same time step.
      @(negedge clk_sys);
      for (n = 0; n < 4000 && cmd_ready !== 1'b1; n++) @(negedge clk_sys);
      if (n == 4000) timed_out();
      {cmd_op, cmd_chan, cmd_src, cmd_dst, cmd_count, cmd_ctrl} =
         {r.op, r.chan, r.src, r.dst, r.cnt, r.ctl};
      slow = r.slow;
      in_start = r.op == 2'h1;
      cmd_valid = 1'b1;
      @(negedge clk_sys);
      cmd_valid = 1'b0;
   endtask : offer
   task automatic run_cmd(input drc_row_t r, output logic got_err);
      int n;
      got_err = 1'b0;
      offer(r);
      for (n = 0; n < 4000 && cmd_ready !== 1'b1; n++) @(negedge clk_sys);
      if (n == 4000) timed_out();
      got_err = cmd_error === 1'b1;
      in_start = 1'b0;
   endtask : run_cmd
   // The request line must stay high for every access of a job start.
   always @(posedge clk_sys) begin
      if (in_start && reg_wr === 1'b1) check(cfg_req_hold === 1'b1, "hold low");
   end
   initial begin
      rows = '{
         '{2'h1, 2'h0, 32'h0040_0000, 32'h0400_0080, 32'h0000_0008, 32'h0001_0001, 1'b0, 1'b0},
         '{2'h1, 2'h1, 32'h0040_0000, 32'h0400_0080, 32'h0000_0006, 32'h0001_0001, 1'b0, 1'b1},
         '{2'h1, 2'h2, 32'h0040_0000, 32'h0400_0080, 32'h0000_0008, 32'h0001_0001, 1'b0, 1'b1},
         '{2'h1, 2'h2, 32'h0040_0000, 32'h0400_0080, 32'h0000_0004, 32'h0001_0001, 1'b1, 1'b0},
         '{2'h1, 2'h3, 32'h0400_0064, 32'h0040_0000, 32'h0000_0004, 32'h0000_0005, 1'b0, 1'b1},
         '{2'h1, 2'h3, 32'h0040_0000, 32'h0400_0200, 32'h0000_0004, 32'h0000_0005, 1'b0, 1'b1},
         '{2'h1, 2'h1, 32'h0040_0000, 32'h0400_0156, 32'h0000_0005, 32'h0000_0005, 1'b1, 1'b0},
         '{2'h0, 2'h0, 32'h0040_0000, 32'h0040_0000, 32'h0000_0004, 32'h0000_0001, 1'b0, 1'b1}};
      repeat (8) @(negedge clk_sys);
      check(cmd_ready === 1'b1 && reg_wr === 1'b0 && stat_valid === 1'b0, "reset");
      check(reg_size === drc_pkg::DRC_SZ_LONG, "reset size");
      rst = 1'b0;
      foreach (rows[i]) begin
         run_cmd(rows[i], ge);
         check(ge === rows[i].err, "job verdict");
      end
      run_cmd('{2'h2, 2'h0, 32'h0, 32'h0, 32'h0, 32'h0, 1'b1, 1'b0}, ge);
      check(standby_ok === 1'b1 && ge === 1'b0, "standby");
      nmi_in = 1'b1;
      @(negedge clk_sys);
      nmi_in = 1'b0;
      // Eight polls fill the status FIFO while the reader stalls.
      repeat (8) run_cmd('{2'h3, 2'h0, 32'h0, 32'h0, 32'h0, 32'h0, 1'b0, 1'b0}, ge);
      offer('{2'h3, 2'h0, 32'h0, 32'h0, 32'h0, 32'h0, 1'b0, 1'b0});
      repeat (20) @(negedge clk_sys);
      check(cmd_ready === 1'b0 && stat_valid === 1'b1, "full FIFO");
      stat_ready = 1'b1;
      got = 0;
      for (int n = 0; n < 200 && got < 9; n++) begin
         if (stat_valid === 1'b1) begin
            check(stat_data === 32'h0000_0002, "status word");
            got++;
         end
         @(negedge clk_sys);
      end
      check(got == 9 && stat_valid === 1'b0 && cmd_ready === 1'b1, "drain");
      run_cmd(rows[0], ge);
      check(standby_ok === 1'b0 && ge === 1'b0, "restart");
      repeat (40) @(negedge clk_sys);
      check(viol_cnt == 0, "device misuse");
      give_verdict();
   end
endmodule : dma_reload_indirect_channel_tb_top
